// File: src/motion_readout_regs.sv
// Read-only status, temperature, fill level and data port registers of a motion sensor.
// Assumes the serial host front end delivers byte-level start, read and stop strobes
// on this clock, and the sensor core drives events and samples on the same clock.
`timescale 1ns/1ps
module motion_readout_regs #(
    parameter int FAST_CYC = motion_readout_pkg::FAST_CYC,
    parameter int SLOW_CYC = motion_readout_pkg::SLOW_CYC,
    parameter int AW       = motion_readout_pkg::QUEUE_AW
) (
    // Clock, reset, enable
    input  wire logic                                CLK_I,
    input  wire logic                                RSTN_I,
    input  wire logic                                CE_I,
    // Host register access
    input  wire motion_readout_pkg::host_req_type    HOST_REQ_I,
    output logic [7:0]                               RDATA_O,
    output logic                                     RVALID_O,
    // Interrupt engine
    input  wire logic [15:0]                         IRQ_EVT_I,
    input  wire logic                                IRQ_LATCH_I,
    input  wire logic                                IRQ_CLR_I,
    input  wire logic [7:0]                          IRQ_DET2_I,
    input  wire motion_readout_pkg::detail_type      DETAIL_I,
    input  wire logic                                FLAT_EN_I,
    input  wire logic                                ORIENT_BLOCK_I,
    input  wire logic                                HIGHG_EVT_I,
    // Temperature and power state
    input  wire logic [15:0]                         TEMP_SAMPLE_I,
    input  wire logic [1:0]                          GYR_PMU_I,
    input  wire logic                                ALL_SUSPEND_I,
    // Frame assembler and command decode
    input  wire motion_readout_pkg::frame_byte_type  FRAME_I,
    input  wire logic                                QUEUE_FLUSH_I,
    input  wire logic                                CFG_CHANGE_I
);

    logic [15:0]                    irq_flags_ff;
    logic [7:0]                     irq_det2_ff;
    motion_readout_pkg::detail_type detail_ff;
    logic [15:0]                    temp_ff;
    logic [31:0]                    tick_ff;
    logic                           slow_ff;
    logic [7:0]                     addr_ff;
    logic                           active_ff;
    logic [7:0]                     nxt_rdata;
    logic [7:0]                     q_data;
    logic                           q_empty;
    logic [AW:0]                    q_count;
    logic [motion_readout_pkg::FILL_BITS-1:0] fill;
    logic                           port_pop;
    logic                           tick_hit;
    logic                           gyr_normal;
    logic                           rd_take;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flags
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            irq_flags_ff <= 16'h0000;
        end else if (CE_I) begin
            // Unlatched flags follow their source; latched ones keep set over clear
            if (IRQ_LATCH_I) begin
                irq_flags_ff <= (irq_flags_ff & ~{16{IRQ_CLR_I}}) | IRQ_EVT_I;
            end else begin
                irq_flags_ff <= IRQ_EVT_I;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            irq_det2_ff <= 8'h00;
        end else if (CE_I) begin
            irq_det2_ff <= IRQ_DET2_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Orientation, flat and high-g detail
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            detail_ff <= '0;
        end else if (CE_I) begin
            detail_ff.flat <= FLAT_EN_I & DETAIL_I.flat;
            // Orientation mode does not gate this, only blocking does
            if (!ORIENT_BLOCK_I) begin
                detail_ff.orient_z  <= DETAIL_I.orient_z;
                detail_ff.orient_xy <= DETAIL_I.orient_xy;
            end
            if (HIGHG_EVT_I) begin
                detail_ff.high_sign <= DETAIL_I.high_sign;
                detail_ff.high_axes <= DETAIL_I.high_axes;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Temperature refresh
    assign gyr_normal = (GYR_PMU_I == motion_readout_pkg::GYR_NORMAL);
    assign tick_hit   = gyr_normal ? (tick_ff >= 32'(FAST_CYC - 1))
                                   : (tick_ff >= 32'(SLOW_CYC - 1));

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            tick_ff <= 32'h0000_0000;
            slow_ff <= 1'b0;
        end else if (CE_I) begin
            slow_ff <= !gyr_normal;
            // A cadence change restarts the period rather than waiting a full slow one
            if (ALL_SUSPEND_I || tick_hit || (slow_ff == gyr_normal)) begin
                tick_ff <= 32'h0000_0000;
            end else begin
                tick_ff <= tick_ff + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            temp_ff <= motion_readout_pkg::TEMP_INVALID;
        end else if (CE_I) begin
            if (ALL_SUSPEND_I) begin
                temp_ff <= motion_readout_pkg::TEMP_INVALID;
            end else if (tick_hit) begin
                // Sample is two's complement around 23 C, 1/512 K per step
                temp_ff <= TEMP_SAMPLE_I;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffer
    // Stop outranks a read in the same cycle, so neither a pop nor an answer follows it
    assign rd_take  = HOST_REQ_I.rd && active_ff && !HOST_REQ_I.start && !HOST_REQ_I.stop;
    assign port_pop = rd_take && (addr_ff == motion_readout_pkg::ADDR_PORT);

    frame_queue #(
        .AW (AW)
    ) u_queue (
        .clk_i      (CLK_I),
        .rstn_i     (RSTN_I),
        .ce_i       (CE_I),
        .flush_i    (QUEUE_FLUSH_I || CFG_CHANGE_I),
        .wr_i       (FRAME_I),
        .rd_pop_i   (port_pop),
        .rd_abort_i (HOST_REQ_I.stop),
        .rd_data_o  (q_data),
        .rd_empty_o (q_empty),
        .count_o    (q_count)
    );

    // Counter is in bytes and already holds any skip frame the assembler wrote
    assign fill = motion_readout_pkg::FILL_BITS'(q_count);

    ////////////////////////////////////////////////////////////////////////////
    // Host read mux
    always_comb begin
        nxt_rdata = 8'h00;
        case (addr_ff)
            8'h1c:   nxt_rdata = irq_flags_ff[7:0];
            8'h1d:   nxt_rdata = irq_flags_ff[15:8];
            8'h1e:   nxt_rdata = irq_det2_ff;
            8'h1f:   nxt_rdata = detail_ff;
            8'h20:   nxt_rdata = temp_ff[7:0];
            8'h21:   nxt_rdata = temp_ff[15:8];
            8'h22:   nxt_rdata = fill[7:0];
            8'h23:   nxt_rdata = {5'h00, fill[10:8]};
            8'h24:   nxt_rdata = q_empty ? motion_readout_pkg::EMPTY_BYTE : q_data;
            default: nxt_rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host address walk
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            addr_ff   <= 8'h00;
            active_ff <= 1'b0;
        end else if (CE_I) begin
            if (HOST_REQ_I.start) begin
                addr_ff   <= HOST_REQ_I.addr;
                active_ff <= 1'b1;
            end else if (HOST_REQ_I.stop) begin
                active_ff <= 1'b0;
            end else if (HOST_REQ_I.rd && active_ff
                         && addr_ff != motion_readout_pkg::ADDR_PORT) begin
                addr_ff <= addr_ff + 8'h01;
            end
        end
    end

    // Port reads touch only the queue, never a new-data flag
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            RDATA_O  <= 8'h00;
            RVALID_O <= 1'b0;
        end else if (CE_I) begin
            RVALID_O <= rd_take;
            if (rd_take) begin
                RDATA_O <= nxt_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    property p_flat_off;
        CE_I && !FLAT_EN_I |=> !detail_ff.flat;
    endproperty
    a_flat_off: assert property (p_flat_off)
        else $error("Flat bit set while flat detection off");

    property p_orient_z_hold;
        CE_I && ORIENT_BLOCK_I |=> detail_ff.orient_z == $past(detail_ff.orient_z);
    endproperty
    a_orient_z_hold: assert property (p_orient_z_hold)
        else $error("Z orientation moved while blocked");

    property p_orient_xy_track;
        CE_I && !ORIENT_BLOCK_I |=> detail_ff.orient_xy == $past(DETAIL_I.orient_xy);
    endproperty
    a_orient_xy_track: assert property (p_orient_xy_track)
        else $error("XY orientation not tracked");

    property p_high_sign;
        CE_I && HIGHG_EVT_I |=> detail_ff.high_sign == $past(DETAIL_I.high_sign);
    endproperty
    a_high_sign: assert property (p_high_sign)
        else $error("High-g sign not captured");

    property p_high_axes;
        CE_I && !HIGHG_EVT_I |=> $stable(detail_ff.high_axes);
    endproperty
    a_high_axes: assert property (p_high_axes)
        else $error("High-g axes changed without event");

    property p_suspend_invalid;
        CE_I && ALL_SUSPEND_I |=> temp_ff == motion_readout_pkg::TEMP_INVALID;
    endproperty
    a_suspend_invalid: assert property (p_suspend_invalid)
        else $error("Temperature live while all suspended");

    property p_temp_cadence;
        CE_I && !ALL_SUSPEND_I && !tick_hit |=> $stable(temp_ff);
    endproperty
    a_temp_cadence: assert property (p_temp_cadence)
        else $error("Temperature refreshed off its tick");

    property p_port_addr;
        CE_I && port_pop && !HOST_REQ_I.start ##1 CE_I && HOST_REQ_I.rd && !HOST_REQ_I.start
            |=> addr_ff == motion_readout_pkg::ADDR_PORT;
    endproperty
    a_port_addr: assert property (p_port_addr)
        else $error("Burst moved off the data port");

    property p_latch_hold;
        CE_I && IRQ_LATCH_I && !IRQ_CLR_I && irq_flags_ff[0] |=> irq_flags_ff[0];
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("Latched flag dropped without clear");

    property p_irq_follow;
        CE_I && !IRQ_LATCH_I |=> irq_flags_ff == $past(IRQ_EVT_I);
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("Unlatched flags did not follow their source");

    property p_orient_xy_hold;
        CE_I && ORIENT_BLOCK_I |=> $stable(detail_ff.orient_xy);
    endproperty
    a_orient_xy_hold: assert property (p_orient_xy_hold)
        else $error("XY orientation moved while blocked");

    property p_high_sign_hold;
        CE_I && !HIGHG_EVT_I |=> $stable(detail_ff.high_sign);
    endproperty
    a_high_sign_hold: assert property (p_high_sign_hold)
        else $error("High-g sign changed without event");

    property p_high_axes_take;
        CE_I && HIGHG_EVT_I |=> detail_ff.high_axes == $past(DETAIL_I.high_axes);
    endproperty
    a_high_axes_take: assert property (p_high_axes_take)
        else $error("High-g axes not captured");

    property p_temp_sample;
        CE_I && !ALL_SUSPEND_I && tick_hit |=> temp_ff == $past(TEMP_SAMPLE_I);
    endproperty
    a_temp_sample: assert property (p_temp_sample)
        else $error("Temperature not refreshed on its tick");

    property p_fill_reserved;
        CE_I && rd_take && addr_ff == motion_readout_pkg::ADDR_FILL + 8'h01
            |=> RDATA_O[7:3] == 5'h00;
    endproperty
    a_fill_reserved: assert property (p_fill_reserved)
        else $error("Reserved fill level bits not zero");

    c_port_burst: cover property (port_pop ##1 port_pop ##1 port_pop);
    c_temp_update: cover property (CE_I && tick_hit && gyr_normal);
    c_abort: cover property (port_pop ##1 HOST_REQ_I.stop);
    c_temp_slow: cover property (CE_I && tick_hit && !gyr_normal);
endmodule

// File: inc/motion_readout_pkg.sv
// Constants, field layouts and carriers of the motion sensor readout registers.
// Assumes one 50 MHz clock shared by the host access logic and the sensor core.
package motion_readout_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0]  ADDR_IRQ      = 8'h1c;
    localparam logic [7:0]  ADDR_TEMP     = 8'h20;
    localparam logic [7:0]  ADDR_FILL     = 8'h22;
    localparam logic [7:0]  ADDR_PORT     = 8'h24;
    localparam logic [7:0]  EMPTY_BYTE    = 8'h80;
    localparam logic [15:0] TEMP_INVALID  = 16'h8000;
    localparam logic [1:0]  GYR_NORMAL    = 2'b01;
    localparam int          FILL_BITS     = 11;
    localparam int          QUEUE_AW      = 10;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ        = 50;
    localparam int FAST_PERIOD_MS = 10;
    localparam int SLOW_PERIOD_MS = 1280;
    localparam int FAST_CYC       = FAST_PERIOD_MS * CLK_MHZ * 1000;
    localparam int SLOW_CYC       = SLOW_PERIOD_MS * CLK_MHZ * 1000;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic       flat;
        logic       orient_z;
        logic [1:0] orient_xy;
        logic       high_sign;
        logic [2:0] high_axes;
    } detail_type;

    typedef struct packed {
        logic       start;
        logic       rd;
        logic       stop;
        logic [7:0] addr;
    } host_req_type;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } frame_byte_type;

endpackage

// File: src/frame_queue.sv
// Byte queue that commits whole frames on both the write and the read side.
// Assumes the writer marks the last byte of every frame and the reader rewinds on abort.
`timescale 1ns/1ps
module frame_queue #(
    parameter int AW = 10
) (
    // Clock, reset, enable
    input  wire logic                               clk_i,
    input  wire logic                               rstn_i,
    input  wire logic                               ce_i,
    // Write side
    input  wire logic                               flush_i,
    input  wire motion_readout_pkg::frame_byte_type wr_i,
    // Read side
    input  wire logic                               rd_pop_i,
    input  wire logic                               rd_abort_i,
    output logic [7:0]                              rd_data_o,
    output logic                                    rd_empty_o,
    output logic [AW:0]                             count_o
);
    localparam logic [AW:0] DEPTH = (AW+1)'(2**AW);

    logic [7:0]  mem_ff  [2**AW];
    logic        last_ff [2**AW];
    logic [AW:0] wc_ff, ws_ff, rc_ff, rs_ff;
    logic        drop_ff;
    logic        room;

    assign room       = (ws_ff - rc_ff) < DEPTH;
    assign rd_empty_o = (rs_ff == wc_ff);
    assign rd_data_o  = mem_ff[rs_ff[AW-1:0]];
    // Only committed frames count, so partial writes and reads never show
    assign count_o    = wc_ff - rc_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    always_ff @(posedge clk_i) begin
        if (ce_i && wr_i.valid && room && !drop_ff) begin
            mem_ff[ws_ff[AW-1:0]]  <= wr_i.data;
            last_ff[ws_ff[AW-1:0]] <= wr_i.last;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write side: a frame that does not fit is dropped whole
    always_ff @(posedge clk_i) begin
        if (!rstn_i || (ce_i && flush_i)) begin
            ws_ff   <= '0;
            wc_ff   <= '0;
            drop_ff <= 1'b0;
        end else if (ce_i && wr_i.valid) begin
            if (drop_ff || !room) begin
                ws_ff   <= wc_ff;
                drop_ff <= !wr_i.last;
            end else begin
                ws_ff <= ws_ff + 1'b1;
                if (wr_i.last) begin
                    wc_ff <= ws_ff + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read side: commit at frame end, rewind an unfinished frame
    always_ff @(posedge clk_i) begin
        if (!rstn_i || (ce_i && flush_i)) begin
            rs_ff <= '0;
            rc_ff <= '0;
        end else if (ce_i && rd_abort_i) begin
            rs_ff <= rc_ff;
        end else if (ce_i && rd_pop_i && !rd_empty_o) begin
            rs_ff <= rs_ff + 1'b1;
            if (last_ff[rs_ff[AW-1:0]]) begin
                rc_ff <= rs_ff + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_count_frames;
        ce_i && !flush_i && !(wr_i.valid && wr_i.last) && !(rd_pop_i && !rd_empty_o)
            |=> $stable(count_o);
    endproperty
    a_count_frames: assert property (p_count_frames)
        else $error("Fill level moved inside a frame");

    property p_flush_zero;
        ce_i && flush_i |=> count_o == '0;
    endproperty
    a_flush_zero: assert property (p_flush_zero)
        else $error("Flush left a nonzero fill level");

    property p_abort_rewind;
        ce_i && rd_abort_i |=> rs_ff == rc_ff;
    endproperty
    a_abort_rewind: assert property (p_abort_rewind)
        else $error("Abort did not rewind to frame start");

    c_drop: cover property (ce_i && wr_i.valid && !room);
endmodule

// File: dv/host_burst_model.sv
// Host side model: opens a register burst, reads bytes back to back, then closes it.
// Assumes the register block answers just after the same edge that takes each read.
`timescale 1ns/1ps
module host_burst_model (
    // Clock and answer
    input  wire logic                        clk_i,
    input  wire logic [7:0]                  rdata_i,
    input  wire logic                        rvalid_i,
    // Request
    output motion_readout_pkg::host_req_type req_o
);
    // Missing answers are kept as unknown so that a compare cannot pass
    logic [7:0] got [0:7];

    initial req_o = '0;

    // Stopping short of a frame end exercises the rewind path
    task automatic burst(input logic [7:0] addr, input int n);
        @(posedge clk_i);
        req_o <= '{start: 1'b1, rd: 1'b0, stop: 1'b0, addr: addr};
        @(posedge clk_i);
        req_o <= '{start: 1'b0, rd: 1'b1, stop: 1'b0, addr: addr};
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            if (i == n - 1) begin
                req_o <= '{start: 1'b0, rd: 1'b0, stop: 1'b1, addr: addr};
            end
            #1;
            got[i] = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
        end
        @(posedge clk_i);
        req_o <= '0;
    endtask
endmodule

// File: dv/motion_temp_fifo_readout_regs_bench.sv
// Self-checking bench of the readout registers, reached through the host model.
// Assumes shortened temperature periods and one 50 MHz clock.
`timescale 1ns/1ps
module motion_temp_fifo_readout_regs_bench;
    localparam int FAST = 20;
    localparam int SLOW = 80;

    logic                               clk;
    logic                               rstn = 1'b0;
    logic                               ce = 1'b1;
    motion_readout_pkg::host_req_type   req;
    logic [7:0]                         rdata;
    logic                               rvalid;
    logic [15:0]                        irq_evt = '0;
    logic                               irq_latch = 1'b0;
    logic                               irq_clr = 1'b0;
    logic [7:0]                         irq_det2 = '0;
    motion_readout_pkg::detail_type     detail = '0;
    logic                               flat_en = 1'b0;
    logic                               orient_block = 1'b0;
    logic                               highg_evt = 1'b0;
    logic [15:0]                        temp_sample = 16'h7fff;
    logic [1:0]                         gyr_pmu = 2'b01;
    logic                               all_suspend = 1'b0;
    motion_readout_pkg::frame_byte_type frame = '0;
    logic                               flush = 1'b0;
    logic                               cfg_change = 1'b0;
    int                                 error_cnt = 0;
    int                                 tests_run = 0;
    int                                 cycles = 0;

    motion_readout_regs #(.FAST_CYC(FAST), .SLOW_CYC(SLOW)) i_dut (
        .CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .HOST_REQ_I(req), .RDATA_O(rdata),
        .RVALID_O(rvalid), .IRQ_EVT_I(irq_evt), .IRQ_LATCH_I(irq_latch),
        .IRQ_CLR_I(irq_clr), .IRQ_DET2_I(irq_det2), .DETAIL_I(detail),
        .FLAT_EN_I(flat_en), .ORIENT_BLOCK_I(orient_block), .HIGHG_EVT_I(highg_evt),
        .TEMP_SAMPLE_I(temp_sample), .GYR_PMU_I(gyr_pmu), .ALL_SUSPEND_I(all_suspend),
        .FRAME_I(frame), .QUEUE_FLUSH_I(flush), .CFG_CHANGE_I(cfg_change));

    host_burst_model i_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic end_sim;
        $display("Checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd8(input logic [7:0] a, input logic [7:0] exp, input string what);
        i_host.burst(a, 1);
        chk(what, {8'h00, exp}, {8'h00, i_host.got[0]});
    endtask

    task automatic rd16(input logic [7:0] a, input logic [15:0] exp, input string what);
        i_host.burst(a, 2);
        chk(what, exp, {i_host.got[1], i_host.got[0]});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Frame bytes; the last one closes the frame only when asked
    task automatic send(input int n, input logic [7:0] base, input bit last);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            frame <= '{valid: 1'b1, last: last && (i == n - 1), data: base + 8'(i)};
        end
        @(posedge clk);
        frame <= '0;
    endtask

    // A hang is cut short well above the expected few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            $display("Error timeout expected done seen busy");
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        idle(4);
        rstn <= 1'b1;
        rd16(motion_readout_pkg::ADDR_TEMP, 16'h8000, "temp reset");
        rd8(motion_readout_pkg::ADDR_PORT, 8'h80, "empty port");
        idle(FAST + 5);
        rd16(motion_readout_pkg::ADDR_TEMP, 16'h7fff, "temp normal");
        all_suspend <= 1'b1;
        idle(FAST + 5);
        rd16(motion_readout_pkg::ADDR_TEMP, 16'h8000, "temp suspend");
        @(posedge clk);
        all_suspend <= 1'b0;
        gyr_pmu <= 2'b00;
        temp_sample <= 16'h0abc;
        idle(30);
        rd16(motion_readout_pkg::ADDR_TEMP, 16'h8000, "temp slow early");
        idle(60);
        rd16(motion_readout_pkg::ADDR_TEMP, 16'h0abc, "temp slow");
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            detail <= '{1'b0, c[0], c[1:0], 1'b0, 3'b000};
            idle(3);
            rd8(8'h1f, {1'b0, c[0], c[1:0], 4'h0}, "orient");
        end
        @(posedge clk);
        detail <= '{1'b1, 1'b1, 2'b10, 1'b1, 3'b101};
        highg_evt <= 1'b1;
        @(posedge clk);
        highg_evt <= 1'b0;
        detail <= '{1'b1, 1'b1, 2'b10, 1'b0, 3'b000};
        idle(3);
        rd8(8'h1f, 8'h6d, "flat off high-g");
        @(posedge clk);
        orient_block <= 1'b1;
        flat_en <= 1'b1;
        detail <= '{1'b1, 1'b0, 2'b01, 1'b0, 3'b010};
        idle(3);
        rd8(8'h1f, 8'hed, "blocked");
        orient_block <= 1'b0;
        idle(3);
        rd8(8'h1f, 8'h9d, "unblocked");
        ce <= 1'b0;
        highg_evt <= 1'b1;
        idle(2);
        highg_evt <= 1'b0;
        ce <= 1'b1;
        idle(2);
        rd8(8'h1f, 8'h9d, "enable freeze");
        @(posedge clk);
        irq_latch <= 1'b1;
        irq_evt <= 16'h0102;
        @(posedge clk);
        irq_evt <= '0;
        idle(3);
        rd16(motion_readout_pkg::ADDR_IRQ, 16'h0102, "latched flags");
        @(posedge clk);
        irq_clr <= 1'b1;
        @(posedge clk);
        irq_clr <= 1'b0;
        idle(2);
        rd16(motion_readout_pkg::ADDR_IRQ, 16'h0000, "cleared flags");
        irq_latch <= 1'b0;
        irq_evt <= 16'h8001;
        irq_det2 <= 8'h5a;
        idle(3);
        i_host.burst(motion_readout_pkg::ADDR_IRQ, 4);
        chk("flag bytes", 16'h8001, {i_host.got[1], i_host.got[0]});
        chk("detail bytes", 16'h9d5a, {i_host.got[3], i_host.got[2]});
        send(2, 8'h10, 1'b0);
        rd16(motion_readout_pkg::ADDR_FILL, 16'h0000, "fill mid frame");
        send(1, 8'h12, 1'b1);
        idle(2);
        rd16(motion_readout_pkg::ADDR_FILL, 16'h0003, "fill frame");
        i_host.burst(motion_readout_pkg::ADDR_PORT, 2);
        chk("part frame", 16'h1011, {i_host.got[0], i_host.got[1]});
        rd16(motion_readout_pkg::ADDR_FILL, 16'h0003, "fill part read");
        i_host.burst(motion_readout_pkg::ADDR_PORT, 3);
        chk("resent head", 16'h1011, {i_host.got[0], i_host.got[1]});
        chk("resent tail", 16'h0012, {8'h00, i_host.got[2]});
        idle(2);
        rd16(motion_readout_pkg::ADDR_FILL, 16'h0000, "fill drained");
        rd8(motion_readout_pkg::ADDR_PORT, 8'h80, "drained port");
        send(4, 8'h20, 1'b1);
        idle(2);
        rd16(motion_readout_pkg::ADDR_FILL, 16'h0004, "fill four");
        @(posedge clk);
        flush <= 1'b1;
        @(posedge clk);
        flush <= 1'b0;
        idle(2);
        rd16(motion_readout_pkg::ADDR_FILL, 16'h0000, "fill flushed");
        send(4, 8'h30, 1'b1);
        @(posedge clk);
        cfg_change <= 1'b1;
        @(posedge clk);
        cfg_change <= 1'b0;
        idle(2);
        rd16(motion_readout_pkg::ADDR_FILL, 16'h0000, "fill format change");
        rd8(8'h30, 8'h00, "unmapped");
        end_sim();
    end
endmodule
